// ---- rtl/dstr_pkg.sv ----
// Shared constants and types for the decoder status and tone register bank.
package dstr_pkg;

    // Bus address of this device on the two-wire control bus, value arbitrary.
    localparam logic [6:0] DEV_ADDR = 7'h43;

    // Byte locations of the register map.
    localparam logic [7:0] ADDR_TALLY_LOW = 8'h67;
    localparam logic [7:0] ADDR_TALLY_MID = 8'h68;
    localparam logic [7:0] ADDR_TALLY_HIGH = 8'h69;
    localparam logic [7:0] ADDR_MEAN_RATE = 8'h6a;
    localparam logic [7:0] ADDR_FW_VERSION = 8'h71;
    localparam logic [7:0] ADDR_DECODE_GO = 8'h72;
    localparam logic [7:0] ADDR_TREBLE_CORNER_LOW = 8'h77;
    localparam logic [7:0] ADDR_TREBLE_CORNER_HIGH = 8'h78;
    localparam logic [7:0] ADDR_BASS_CORNER_LOW = 8'h79;
    localparam logic [7:0] ADDR_BASS_CORNER_HIGH = 8'h7a;
    localparam logic [7:0] ADDR_TREBLE_GAIN = 8'h7b;
    localparam logic [7:0] ADDR_BASS_GAIN = 8'h7c;
    localparam logic [7:0] ADDR_TONE_HEADROOM = 8'h7d;

    // Writable registers, their index, location and implemented bits.
    localparam int RW_COUNT = 8;
    localparam int IDX_GO = 0;
    localparam int IDX_TREBLE_LOW = 1;
    localparam int IDX_TREBLE_HIGH = 2;
    localparam int IDX_BASS_LOW = 3;
    localparam int IDX_BASS_HIGH = 4;
    localparam int IDX_TREBLE_GAIN = 5;
    localparam int IDX_BASS_GAIN = 6;
    localparam int IDX_HEADROOM = 7;
    localparam logic [7:0] RW_ADDR [RW_COUNT] = '{
        ADDR_DECODE_GO, ADDR_TREBLE_CORNER_LOW, ADDR_TREBLE_CORNER_HIGH,
        ADDR_BASS_CORNER_LOW, ADDR_BASS_CORNER_HIGH, ADDR_TREBLE_GAIN,
        ADDR_BASS_GAIN, ADDR_TONE_HEADROOM};
    localparam logic [7:0] RW_MASK [RW_COUNT] = '{
        8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

    // Reset values and field positions.
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int TALLY_W = 24;
    localparam logic [TALLY_W-1:0] TALLY_RESET = 24'h000000;
    localparam int GO_BIT = 0;

    // Tone settings are rescaled to half-decibel units: one unit is 1.5 dB.
    localparam int HDB_W = 10;
    localparam logic signed [HDB_W-1:0] TONE_STEP_HDB = 10'sh003;
    localparam logic [HDB_W-1:0] HDB_RESET = 10'h000;

    // Bus engine states, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RX = 6'h02,
        ST_ACK = 6'h04,
        ST_TX = 6'h08,
        ST_RACK = 6'h10,
        ST_LOAD = 6'h20
    } dstr_state_e;

    // Meaning of the next received byte, one-hot.
    typedef enum logic [2:0] {
        PH_ADDR = 3'h1,
        PH_PTR = 3'h2,
        PH_DATA = 3'h4
    } dstr_phase_e;

endpackage

// ---- rtl/dstr_frame_tally.sv ----
// Decoded-frame tally counter with clear and natural wrap.
`timescale 1ns/1ns
module dstr_frame_tally (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic clr_i,
    input wire logic step_i,
    output logic [dstr_pkg::TALLY_W-1:0] count_o
);

    // Clear has priority so a frame in the reset cycle is not counted.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_o <= dstr_pkg::TALLY_RESET; // R03
        end else if (ce_i && clr_i) begin
            count_o <= dstr_pkg::TALLY_RESET; // R03
        end else if (ce_i && step_i) begin
            count_o <= count_o + 24'h000001; // R02 R19
        end
    end

    property p_tally_step;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && step_i && !clr_i) |=> (count_o == $past(count_o) + 24'h000001);
    endproperty
    a_tally_step: assert property (p_tally_step) // R02
        else $error("Frame tally did not advance.");

    property p_tally_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        !(ce_i && (step_i || clr_i)) |=> $stable(count_o);
    endproperty
    a_tally_hold: assert property (p_tally_hold) // R02
        else $error("Frame tally moved without a frame.");

    property p_tally_wrap;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && step_i && !clr_i && count_o == 24'hffffff) |=> (count_o == 24'h000000);
    endproperty
    a_tally_wrap: assert property (p_tally_wrap) // R19
        else $error("Frame tally did not wrap to zero.");

    property p_tally_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        (ce_i && clr_i) |=> (count_o == 24'h000000);
    endproperty
    a_tally_clear: assert property (p_tally_clear) // R03
        else $error("Frame tally not cleared by software reset.");

endmodule // dstr_frame_tally

// ---- rtl/dstr_tone_scale.sv ----
// Rescales tone gain and headroom bytes into half-decibel control words.
`timescale 1ns/1ns
module dstr_tone_scale (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] treble_gain_i,
    input wire logic [7:0] bass_gain_i,
    input wire logic [7:0] headroom_i,
    output logic signed [dstr_pkg::HDB_W-1:0] treble_hdb_o,
    output logic signed [dstr_pkg::HDB_W-1:0] bass_hdb_o,
    output logic [dstr_pkg::HDB_W-1:0] headroom_hdb_o
);

    logic [7:0] gain_in [2];
    logic signed [dstr_pkg::HDB_W-1:0] gain_hdb [2];

    assign gain_in[0] = treble_gain_i;
    assign gain_in[1] = bass_gain_i;
    assign treble_hdb_o = gain_hdb[0];
    assign bass_hdb_o = gain_hdb[1];

    // Each gain lane is sign-extended before scaling so cuts stay negative.
    for (genvar i = 0; i < 2; i++) begin : g_lane
        logic signed [dstr_pkg::HDB_W-1:0] ext;
        logic signed [dstr_pkg::HDB_W-1:0] next_hdb;
        assign ext = {{2{gain_in[i][7]}}, gain_in[i]};
        assign next_hdb = ext * dstr_pkg::TONE_STEP_HDB; // R13 R14
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                gain_hdb[i] <= dstr_pkg::HDB_RESET;
            end else if (ce_i) begin
                gain_hdb[i] <= next_hdb;
            end
        end
    end

    // Headroom is unsigned; large values are passed on, not clipped.
    logic [dstr_pkg::HDB_W-1:0] next_headroom;
    assign next_headroom = {2'b00, headroom_i} * dstr_pkg::TONE_STEP_HDB; // R16

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            headroom_hdb_o <= dstr_pkg::HDB_RESET;
        end else if (ce_i) begin
            headroom_hdb_o <= next_headroom;
        end
    end

    property p_treble_scale;
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> (treble_hdb_o == 3 * $signed($past(treble_gain_i)));
    endproperty
    a_treble_scale: assert property (p_treble_scale) // R13
        else $error("Treble gain scaling wrong.");

    property p_bass_scale;
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> (bass_hdb_o == 3 * $signed($past(bass_gain_i)));
    endproperty
    a_bass_scale: assert property (p_bass_scale) // R14
        else $error("Bass gain scaling wrong.");

    property p_headroom_scale;
        @(posedge clk_i) disable iff (!rst_n_i)
        ce_i |=> (headroom_hdb_o == 3 * $past(headroom_i));
    endproperty
    a_headroom_scale: assert property (p_headroom_scale) // R16
        else $error("Tone headroom scaling wrong.");

endmodule // dstr_tone_scale

// ---- rtl/dstr_regs.sv ----
// Status and tone register bank of the audio decoder on the two-wire bus.
//
// Behaviour
// [R01] 24-bit frame tally in three bytes, low byte at lowest location.
// [R02] Tally advances once per decoded frame; host can only read it.
// [R03] Hardware and software reset clear all three tally bytes.
// [R04] Read-only byte reports mean input bitrate in whole kbit/s.
// [R05] After boot a read-only byte holds the firmware version code.
// [R06] Writing one to run bit zero starts decoding.
// [R07] Host sets the run bit only after all control registers are set.
// [R08] Two bytes form unsigned 16-bit treble corner frequency in hertz.
// [R09] Host keeps treble corner below half the sample rate.
// [R10] Two bytes form unsigned 16-bit bass corner frequency in hertz.
// [R11] Host keeps bass corner above zero, not above treble corner.
// [R12] Host should keep bass corner within 20 Hz to 750 Hz.
// [R13] Treble gain byte is signed; each unit is 1.5 dB.
// [R14] Bass gain byte is signed; each unit is 1.5 dB.
// [R15] Host keeps each tone gain within twelve units either way.
// [R16] Headroom byte attenuates output by 1.5 dB per unsigned unit.
// [R17] Host sets headroom to at least the largest planned boost.
// [R18] Registers are byte locations reached over the two-wire bus.
// [R19] Frame tally wraps from its maximum to zero.
`timescale 1ns/1ns
module dstr_regs (
    input wire logic MCLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic SW_RESET_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic FRAME_DONE_I,
    input wire logic [7:0] MEAN_RATE_I,
    input wire logic BOOT_DONE_I,
    input wire logic [7:0] VERSION_I,
    output logic SDA_O,
    output logic SDA_OE_N_O,
    output logic DECODE_GO_O,
    output logic [15:0] TREBLE_CORNER_O,
    output logic [15:0] BASS_CORNER_O,
    output logic signed [dstr_pkg::HDB_W-1:0] TREBLE_GAIN_HDB_O,
    output logic signed [dstr_pkg::HDB_W-1:0] BASS_GAIN_HDB_O,
    output logic [dstr_pkg::HDB_W-1:0] HEADROOM_HDB_O
);

    dstr_pkg::dstr_state_e state;
    dstr_pkg::dstr_phase_e phase;
    logic scl_q;
    logic sda_q;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic rnw;
    logic [7:0] ptr;
    logic sda_oe_n;
    logic sda_lvl;
    logic [7:0] mean_rate;
    logic [7:0] version;
    logic [7:0] snap_mid;
    logic [7:0] snap_high;
    logic [dstr_pkg::TALLY_W-1:0] tally;
    logic [7:0] rw_val [dstr_pkg::RW_COUNT];
    logic [7:0] rd_acc [dstr_pkg::RW_COUNT+1];

    // Bus pins are already synchronous, so one stage of history gives edges.
    wire scl_rise = SCL_I & ~scl_q;
    wire scl_fall = ~SCL_I & scl_q;
    wire bus_start = SCL_I & scl_q & sda_q & ~SDA_I;
    wire bus_stop = SCL_I & scl_q & ~sda_q & SDA_I;
    wire byte_end = (bit_cnt == 3'h7);
    wire [7:0] rx_byte = {shift[6:0], SDA_I};
    wire addr_hit = (rx_byte[7:1] == dstr_pkg::DEV_ADDR);
    wire sw_clr = CE_I & SW_RESET_I;

    // A data byte is written on the rising clock of its last bit.
    wire wr_en = CE_I & (state == dstr_pkg::ST_RX) & scl_rise & byte_end
        & (phase == dstr_pkg::PH_DATA); // R18

    // Read data is loaded after an address ack or a master ack.
    wire tx_load = scl_fall & (((state == dstr_pkg::ST_ACK) & ~sda_oe_n & rnw)
        | (state == dstr_pkg::ST_LOAD));

    // Writable registers share one write path and one read chain.
    assign rd_acc[0] = 8'h00;
    for (genvar i = 0; i < dstr_pkg::RW_COUNT; i++) begin : g_rw
        logic [7:0] val;
        wire hit = (ptr == dstr_pkg::RW_ADDR[i]);
        assign rw_val[i] = val;
        assign rd_acc[i+1] = rd_acc[i] | (hit ? val : 8'h00);
        always_ff @(posedge MCLK_I or negedge RST_N_I) begin
            if (!RST_N_I) begin
                val <= dstr_pkg::REG_RESET;
            end else if (sw_clr) begin
                val <= dstr_pkg::REG_RESET;
            end else if (wr_en && hit) begin
                val <= rx_byte & dstr_pkg::RW_MASK[i]; // R06 R08 R10
            end
        end
    end

    // Read selection; tally upper bytes come from the snapshot taken
    // when the low byte is read, so a frame between reads cannot tear it.
    wire [7:0] rd_data =
        (ptr == dstr_pkg::ADDR_TALLY_LOW) ? tally[7:0] : // R01
        (ptr == dstr_pkg::ADDR_TALLY_MID) ? snap_mid : // R01
        (ptr == dstr_pkg::ADDR_TALLY_HIGH) ? snap_high : // R01
        (ptr == dstr_pkg::ADDR_MEAN_RATE) ? mean_rate : // R04
        (ptr == dstr_pkg::ADDR_FW_VERSION) ? version : // R05
        rd_acc[dstr_pkg::RW_COUNT];

    // Run bit and corner outputs come straight from the register flops.
    assign DECODE_GO_O = rw_val[dstr_pkg::IDX_GO][dstr_pkg::GO_BIT]; // R06
    assign TREBLE_CORNER_O = {rw_val[dstr_pkg::IDX_TREBLE_HIGH],
        rw_val[dstr_pkg::IDX_TREBLE_LOW]}; // R08
    assign BASS_CORNER_O = {rw_val[dstr_pkg::IDX_BASS_HIGH],
        rw_val[dstr_pkg::IDX_BASS_LOW]}; // R10
    assign SDA_OE_N_O = sda_oe_n;
    assign SDA_O = sda_lvl;

    dstr_frame_tally u_tally (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .clr_i(SW_RESET_I),
        .step_i(FRAME_DONE_I),
        .count_o(tally)
    );

    dstr_tone_scale u_tone (
        .clk_i(MCLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .treble_gain_i(rw_val[dstr_pkg::IDX_TREBLE_GAIN]),
        .bass_gain_i(rw_val[dstr_pkg::IDX_BASS_GAIN]),
        .headroom_i(rw_val[dstr_pkg::IDX_HEADROOM]),
        .treble_hdb_o(TREBLE_GAIN_HDB_O),
        .bass_hdb_o(BASS_GAIN_HDB_O),
        .headroom_hdb_o(HEADROOM_HDB_O)
    );

    // Status captures: rate follows the core, version is caught after boot.
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mean_rate <= dstr_pkg::REG_RESET;
            version <= dstr_pkg::REG_RESET;
            snap_mid <= dstr_pkg::REG_RESET;
            snap_high <= dstr_pkg::REG_RESET;
            sda_lvl <= 1'b0;
        end else if (CE_I) begin
            mean_rate <= SW_RESET_I ? dstr_pkg::REG_RESET : MEAN_RATE_I; // R04
            if (BOOT_DONE_I) begin
                version <= VERSION_I; // R05
            end
            if (SW_RESET_I) begin
                snap_mid <= dstr_pkg::REG_RESET; // R03
                snap_high <= dstr_pkg::REG_RESET; // R03
            end else if (tx_load && ptr == dstr_pkg::ADDR_TALLY_LOW) begin
                snap_mid <= tally[15:8]; // R01
                snap_high <= tally[23:16]; // R01
            end
        end
    end

    // Pin history for edge and start/stop detection.
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (CE_I) begin
            scl_q <= SCL_I;
            sda_q <= SDA_I;
        end
    end

    // Bus engine. Stop and start win over any byte in flight; the line is
    // released at once so a bus reset by the master never hangs on us.
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= dstr_pkg::ST_IDLE;
            phase <= dstr_pkg::PH_ADDR;
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            rnw <= 1'b0;
            ptr <= 8'h00;
            sda_oe_n <= 1'b1;
        end else if (CE_I) begin
            if (bus_stop) begin
                state <= dstr_pkg::ST_IDLE;
                sda_oe_n <= 1'b1;
            end else if (bus_start) begin
                state <= dstr_pkg::ST_RX;
                phase <= dstr_pkg::PH_ADDR;
                bit_cnt <= 3'h0;
                sda_oe_n <= 1'b1;
            end else if (tx_load) begin
                // First bit goes out at once; pointer moves on for the next read.
                state <= dstr_pkg::ST_TX;
                shift <= rd_data;
                sda_oe_n <= rd_data[7]; // R18
                bit_cnt <= 3'h0;
                ptr <= ptr + 8'h01;
            end else begin
                unique case (state)
                    dstr_pkg::ST_IDLE: begin
                        bit_cnt <= 3'h0;
                    end
                    dstr_pkg::ST_RX: begin
                        if (scl_rise) begin
                            shift <= rx_byte;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (byte_end && phase == dstr_pkg::PH_ADDR) begin
                                rnw <= SDA_I;
                                phase <= SDA_I ? dstr_pkg::PH_DATA : dstr_pkg::PH_PTR;
                                state <= addr_hit ? dstr_pkg::ST_ACK : dstr_pkg::ST_IDLE;
                            end else if (byte_end && phase == dstr_pkg::PH_PTR) begin
                                ptr <= rx_byte; // R18
                                phase <= dstr_pkg::PH_DATA;
                                state <= dstr_pkg::ST_ACK;
                            end else if (byte_end) begin
                                ptr <= ptr + 8'h01; // R18
                                state <= dstr_pkg::ST_ACK;
                            end
                        end
                    end
                    dstr_pkg::ST_ACK: begin
                        // First fall pulls the ack low, second fall ends it.
                        if (scl_fall && sda_oe_n) begin
                            sda_oe_n <= 1'b0;
                        end else if (scl_fall) begin
                            sda_oe_n <= 1'b1;
                            state <= dstr_pkg::ST_RX;
                        end
                    end
                    dstr_pkg::ST_TX: begin
                        if (scl_fall) begin
                            bit_cnt <= bit_cnt + 3'h1;
                            if (byte_end) begin
                                sda_oe_n <= 1'b1;
                                state <= dstr_pkg::ST_RACK;
                            end else begin
                                shift <= {shift[6:0], 1'b0};
                                sda_oe_n <= shift[6];
                            end
                        end
                    end
                    dstr_pkg::ST_RACK: begin
                        // A not-acknowledge ends the read; wait for stop.
                        if (scl_rise) begin
                            state <= SDA_I ? dstr_pkg::ST_IDLE : dstr_pkg::ST_LOAD;
                        end
                    end
                    dstr_pkg::ST_LOAD: begin
                        bit_cnt <= 3'h0;
                    end
                    default: begin
                        state <= dstr_pkg::ST_IDLE;
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

    // The tally cannot be written: its locations are outside the write table.
    property p_tally_ro;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (wr_en && ptr >= dstr_pkg::ADDR_TALLY_LOW && ptr <= dstr_pkg::ADDR_TALLY_HIGH
            && !FRAME_DONE_I && !SW_RESET_I)
            |=> (tally == $past(tally));
    endproperty
    a_tally_ro: assert property (p_tally_ro) // R02
        else $error("Frame tally changed by a bus write.");

    property p_sw_clear;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        sw_clr |=> (!DECODE_GO_O && TREBLE_CORNER_O == 16'h0000
            && BASS_CORNER_O == 16'h0000 && mean_rate == 8'h00);
    endproperty
    a_sw_clear: assert property (p_sw_clear) // R03
        else $error("Software reset did not clear registers.");

    property p_go_set;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (wr_en && !SW_RESET_I && ptr == dstr_pkg::ADDR_DECODE_GO)
            |=> (DECODE_GO_O == $past(SDA_I));
    endproperty
    a_go_set: assert property (p_go_set) // R06
        else $error("Run bit does not follow the written bit zero.");

    property p_rate_follow;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (CE_I && !SW_RESET_I) |=> (mean_rate == $past(MEAN_RATE_I));
    endproperty
    a_rate_follow: assert property (p_rate_follow) // R04
        else $error("Mean rate byte not tracking the core.");

    property p_version_boot;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (CE_I && BOOT_DONE_I) |=> (version == $past(VERSION_I));
    endproperty
    a_version_boot: assert property (p_version_boot) // R05
        else $error("Version not captured after boot.");

    property p_treble_low;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (wr_en && !SW_RESET_I && ptr == dstr_pkg::ADDR_TREBLE_CORNER_LOW)
            |=> (TREBLE_CORNER_O[7:0] == $past(rx_byte))
            && $stable(TREBLE_CORNER_O[15:8]);
    endproperty
    a_treble_low: assert property (p_treble_low) // R08
        else $error("Treble corner low byte write lost.");

    property p_bass_high;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (wr_en && !SW_RESET_I && ptr == dstr_pkg::ADDR_BASS_CORNER_HIGH)
            |=> (BASS_CORNER_O[15:8] == $past(rx_byte))
            && $stable(BASS_CORNER_O[7:0]);
    endproperty
    a_bass_high: assert property (p_bass_high) // R10
        else $error("Bass corner high byte write lost.");

    property p_addr_ack;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (CE_I && state == dstr_pkg::ST_RX && phase == dstr_pkg::PH_ADDR
            && scl_rise && byte_end && addr_hit && !bus_start && !bus_stop)
            |=> (state == dstr_pkg::ST_ACK) && sda_oe_n;
    endproperty
    a_addr_ack: assert property (p_addr_ack) // R18
        else $error("Own bus address not acknowledged.");

    // A foreign address is ignored; a low tally read freezes the upper bytes beside it.
    property p_foreign_ignore;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (CE_I && state == dstr_pkg::ST_RX && phase == dstr_pkg::PH_ADDR
            && scl_rise && byte_end && !addr_hit)
            |=> (state == dstr_pkg::ST_IDLE) && sda_oe_n;
    endproperty
    a_foreign_ignore: assert property (p_foreign_ignore) // R18
        else $error("Foreign bus address was answered.");

    property p_tally_snap;
        @(posedge MCLK_I) disable iff (!RST_N_I)
        (CE_I && tx_load && !SW_RESET_I && ptr == dstr_pkg::ADDR_TALLY_LOW)
            |=> ({snap_high, snap_mid} == $past(tally[23:8]));
    endproperty
    a_tally_snap: assert property (p_tally_snap) // R01
        else $error("Tally upper bytes not captured with the low byte.");

endmodule // dstr_regs

// ---- test/dstr_host.sv ----
// Behavioural host controller that masters the two-wire register bus.
`timescale 1ns/1ns
module dstr_host (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    logic [6:0] dev = dstr_pkg::DEV_ADDR;
    // Both lines rest high; a released data line reads high through the pull-up.
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Each step holds the lines two cycles, so no change ever meets a rising clock edge.
    task automatic st(input logic c, input logic s);
        scl_o = c;
        sda_o = s;
        repeat (2) @(negedge clk_i);
    endtask
    // Data changes only while the clock is low and is read in the high phase.
    task automatic bitx(input logic b, output logic r);
        st(1'b0, b);
        st(1'b1, b);
        r = sda_i;
        st(1'b1, b);
        st(1'b0, b);
    endtask
    // A byte goes out MSB first; the ninth clock leaves the line to the device.
    task automatic byt(input logic [7:0] v, output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(v[i], s);
            r[i] = s;
        end
        bitx(1'b1, s);
        ack = ~s;
    endtask
    task automatic start();
        st(1'b0, 1'b1);
        st(1'b1, 1'b1);
        st(1'b1, 1'b0);
        st(1'b0, 1'b0);
    endtask
    // One byte location per transfer; a read ends with a not-acknowledge.
    task automatic xfer(input logic [7:0] a, input logic [7:0] v, input logic rd,
                        output logic [7:0] r, output logic ok);
        logic [7:0] x;
        logic k1, k2, k3, kx;
        start();
        byt({dev, 1'b0}, x, k1);
        byt(a, x, k2);
        if (rd) begin
            start();
            byt({dev, 1'b1}, x, k3);
            byt(8'hff, r, kx);
        end else begin
            byt(v, x, k3);
        end
        st(1'b0, 1'b0);
        st(1'b1, 1'b0);
        st(1'b1, 1'b1);
        ok = k1 & k2 & k3;
    endtask
endmodule // dstr_host

// ---- test/dstr_regs_tb_top.sv ----
// Self-checking bench for the decoder status and tone register bank.
`timescale 1ns/1ns
module dstr_regs_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sw_reset = 1'b0;
    logic ce = 1'b1;
    logic frame_done = 1'b0;
    logic boot_done = 1'b0;
    logic [7:0] mean_rate = 8'h00;
    logic [7:0] version = 8'h00;
    logic scl, hsda, sda_w, sda_o, sda_oe_n, go, ok;
    logic [15:0] treble_c, bass_c;
    logic signed [dstr_pkg::HDB_W-1:0] tg, bg;
    logic [dstr_pkg::HDB_W-1:0] hr;
    logic [7:0] d;
    int bad_count = 0;
    int check_count = 0;
    localparam logic [7:0] CFG_A [7] = '{8'h7d, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c};
    localparam logic [7:0] CFG_D [7] = '{8'h0c, 8'hb8, 8'h0b, 8'hc8, 8'h00, 8'h0c, 8'hf4};
    always #10 clk = ~clk;
    // The device only ever pulls the line low; otherwise the pull-up wins.
    assign sda_w = hsda & sda_oe_n;
    dstr_host i_host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(hsda));
    dstr_regs i_dut (.MCLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .SW_RESET_I(sw_reset),
        .SCL_I(scl), .SDA_I(sda_w), .FRAME_DONE_I(frame_done), .MEAN_RATE_I(mean_rate),
        .BOOT_DONE_I(boot_done), .VERSION_I(version), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n),
        .DECODE_GO_O(go), .TREBLE_CORNER_O(treble_c), .BASS_CORNER_O(bass_c),
        .TREBLE_GAIN_HDB_O(tg), .BASS_GAIN_HDB_O(bg), .HEADROOM_HDB_O(hr));
    task automatic check(input string w, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", w, exp, seen);
        end
    endtask
    // The acknowledge travels in the upper byte so one compare covers both.
    task automatic rdc(input string w, input logic [7:0] a, input logic [7:0] e);
        i_host.xfer(a, 8'h00, 1'b1, d, ok);
        check(w, {7'h00, ok, d}, {8'h01, e});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // A hung bus transfer must not stall the run for ever.
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        summarize();
    end
    // Tests run in order; inputs move only on the falling clock edge.
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        for (int a = 8'h67; a < 8'h7e; a++) begin
            rdc("reset value", 8'(a), 8'h00);
        end
        $display("test reset values done");
        for (int i = 0; i < 7; i++) begin
            i_host.xfer(CFG_A[i], CFG_D[i], 1'b0, d, ok);
            check("write ack", {15'h0000, ok}, 16'h0001);
            rdc("readback", CFG_A[i], CFG_D[i]);
        end
        check("treble corner", treble_c, 16'h0bb8);
        check("bass corner", bass_c, 16'h00c8);
        check("treble gain", tg, 10'(12 * 3));
        check("bass gain", bg, 10'(-12 * 3));
        check("headroom", hr, 10'(12 * 3));
        check("data level", {15'h0000, sda_o}, 16'h0000);
        check("idle", {15'h0000, go}, 16'h0000);
        i_host.xfer(8'h72, 8'hff, 1'b0, d, ok);
        check("run", {15'h0000, go}, 16'h0001);
        rdc("run byte", 8'h72, 8'h01);
        $display("test tone setup done");
        repeat (259) begin
            frame_done = 1'b1;
            @(negedge clk);
            frame_done = 1'b0;
            @(negedge clk);
        end
        i_host.xfer(8'h68, 8'haa, 1'b0, d, ok);
        rdc("tally low", 8'h67, 8'h03);
        rdc("tally mid", 8'h68, 8'h01);
        rdc("tally high", 8'h69, 8'h00);
        // A low clock enable must swallow frame pulses.
        ce = 1'b0;
        frame_done = 1'b1;
        repeat (4) @(negedge clk);
        ce = 1'b1;
        frame_done = 1'b0;
        rdc("tally frozen", 8'h67, 8'h03);
        mean_rate = 8'h80;
        boot_done = 1'b1;
        version = 8'h5a;
        rdc("mean rate", 8'h6a, 8'h80);
        rdc("version", 8'h71, 8'h5a);
        $display("test status done");
        sw_reset = 1'b1;
        @(negedge clk);
        sw_reset = 1'b0;
        rdc("tally cleared", 8'h67, 8'h00);
        check("run cleared", {15'h0000, go}, 16'h0000);
        i_host.dev = 7'h44;
        i_host.xfer(8'h7b, 8'h01, 1'b0, d, ok);
        check("foreign ack", {15'h0000, ok}, 16'h0000);
        i_host.dev = dstr_pkg::DEV_ADDR;
        rdc("foreign write", 8'h7b, 8'h00);
        $display("test soft reset done");
        summarize();
    end
endmodule // dstr_regs_tb_top
